/* File: src/dpip_defines.svh */
/*
 * offsets, field positions, masks, reset images and answer codes for the
 * dma/parallel-port interrupt priority registers.
 * assumes a 32-bit axi4-lite slave, word-aligned registers, 16-bit images.
 */
//
// Contract
// - dma ch3 priority at bits 2:0
// - dma ch4 priority at bits 10:8
// - field 111 means level seven, highest
// - 001 upward map to levels one-seven
// - field 000 disables the source
// - every field resets to 100
// - unimplemented bits read zero, ignore writes
// - can sources disabled when can absent
//
`ifndef DPIP_DEFINES_SVH
`define DPIP_DEFINES_SVH

`define DPIP_AW          8
`define DPIP_DW          32
`define DPIP_FW          3
`define DPIP_NSRC        5

////////////////////////////////////////////////////////////////////////////////
// register offsets (byte addresses)
`define DPIP_OFS_CH3     8'h00
`define DPIP_OFS_CH4PP   8'h04
`define DPIP_OFS_CAN     8'h08
`define DPIP_OFS_STAT    8'h0c

////////////////////////////////////////////////////////////////////////////////
// field positions (lsb)
`define DPIP_CH3_LSB     0
`define DPIP_CH4_LSB     8
`define DPIP_PP_LSB      4
`define DPIP_CANRX_LSB   0
`define DPIP_CANEV_LSB   4

////////////////////////////////////////////////////////////////////////////////
// implemented bits and reset images
`define DPIP_CH3_MASK    16'h0007
`define DPIP_CH4PP_MASK  16'h0770
`define DPIP_CAN_MASK    16'h0077
`define DPIP_CH3_RST     16'h0004
`define DPIP_CH4PP_RST   16'h0440
`define DPIP_CAN_RST     16'h0044

////////////////////////////////////////////////////////////////////////////////
// priority codes and bus answers
`define DPIP_PRIO_RST    3'h4
`define DPIP_PRIO_OFF    3'h0
`define DPIP_PRIO_MAX    3'h7
`define DPIP_RESP_OKAY   2'h0
`define DPIP_RESP_DECERR 2'h3

`endif

/* File: src/dpip_pkg.sv */
/*
 * types shared by the priority register block and its bus slave.
 * assumes dpip_defines.svh is on the include path.
 */
`default_nettype none
`include "dpip_defines.svh"

package dpip_pkg;

    typedef logic [`DPIP_FW-1:0] dpip_level_t;

    // one register write as the slave hands it over
    typedef struct packed {
        logic [`DPIP_AW-1:0] addr;
        logic [`DPIP_DW-1:0] data;
        logic [3:0]          strb;
    } dpip_wr_s;

    // effective priority level per source
    typedef struct packed {
        dpip_level_t can_evt;
        dpip_level_t can_rx;
        dpip_level_t pp;
        dpip_level_t ch4;
        dpip_level_t ch3;
    } dpip_levels_s;

endpackage

`default_nettype wire

/* File: src/dpip_sync3.sv */
/*
 * three-stage synchroniser for one asynchronous level.
 * assumes the caller compares only the second and third stages.
 */
`timescale 1ns/1ps
`default_nettype none

module dpip_sync3 (
    // clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // level
    input  wire logic async_in,
    output logic      sync_q2,
    output logic      sync_q3
);

    logic stage1_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stage1_reg <= 1'b0;
            sync_q2    <= 1'b0;
            sync_q3    <= 1'b0;
        end else begin
            stage1_reg <= async_in;
            sync_q2    <= stage1_reg;
            sync_q3    <= sync_q2;
        end
    end

endmodule

`default_nettype wire

/* File: src/dpip_axil_slave.sv */
/*
 * axi4-lite slave front end: one write and one read under way at a time.
 * assumes the user side decodes the address combinationally in the fire cycle.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dpip_defines.svh"

module dpip_axil_slave (
    // clock and reset
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    // write address and data
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [`DPIP_AW-1:0]  s_axi_awaddr,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    input  wire logic [`DPIP_DW-1:0]  s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    // write response
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    output logic [1:0]                s_axi_bresp,
    // read address
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    input  wire logic [`DPIP_AW-1:0]  s_axi_araddr,
    // read data
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    output logic [`DPIP_DW-1:0]       s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    // user side
    output dpip_pkg::dpip_wr_s        wr,
    output logic                      wr_fire,
    input  wire logic                 wr_ok,
    output logic [`DPIP_AW-1:0]       rd_addr,
    output logic                      rd_fire,
    input  wire logic [`DPIP_DW-1:0]  rd_data,
    input  wire logic                 rd_ok
);

    logic [`DPIP_AW-1:0] awaddr_reg;
    logic [`DPIP_DW-1:0] wdata_reg;
    logic [3:0]          wstrb_reg;
    logic                aw_full_reg;
    logic                w_full_reg;
    logic                ar_pend_reg;

    wire aw_hs = s_axi_awvalid & s_axi_awready;
    wire w_hs  = s_axi_wvalid & s_axi_wready;
    wire b_hs  = s_axi_bvalid & s_axi_bready;
    wire ar_hs = s_axi_arvalid & s_axi_arready;
    wire r_hs  = s_axi_rvalid & s_axi_rready;

    assign wr_fire = aw_full_reg & w_full_reg & ~s_axi_bvalid;
    assign wr      = '{addr: awaddr_reg, data: wdata_reg, strb: wstrb_reg};
    assign rd_fire = ar_pend_reg & ~s_axi_rvalid;

    ////////////////////////////////////////////////////////////////////////////
    // write path: address and data caught in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            aw_full_reg   <= 1'b0;
            w_full_reg    <= 1'b0;
            awaddr_reg    <= '0;
            wdata_reg     <= '0;
            wstrb_reg     <= '0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `DPIP_RESP_OKAY;
        end else begin
            if (aw_hs) begin
                awaddr_reg    <= s_axi_awaddr;
                aw_full_reg   <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (w_hs) begin
                wdata_reg    <= s_axi_wdata;
                wstrb_reg    <= s_axi_wstrb;
                w_full_reg   <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_full_reg  <= 1'b0;
                w_full_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? `DPIP_RESP_OKAY : `DPIP_RESP_DECERR;
            end
            // readies return only once the response is gone
            if (b_hs) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read path
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            ar_pend_reg   <= 1'b0;
            rd_addr       <= '0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= `DPIP_RESP_OKAY;
        end else begin
            if (ar_hs) begin
                rd_addr       <= s_axi_araddr;
                ar_pend_reg   <= 1'b1;
                s_axi_arready <= 1'b0;
            end
            if (rd_fire) begin
                ar_pend_reg  <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_data;
                s_axi_rresp  <= rd_ok ? `DPIP_RESP_OKAY : `DPIP_RESP_DECERR;
            end
            if (r_hs) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

/* File: src/dpip_prio_regs.sv */
/*
 * interrupt priority registers for dma ch3, dma ch4, the parallel port and
 * two can sources, with effective levels and per-source service gating.
 * assumes irq_pend comes from logic on aclk; can_present_pin is a strap
 * from a pin and may change at any time.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dpip_defines.svh"

module dpip_prio_regs (
    // clock and reset
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    // axi4-lite write address and data
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [`DPIP_AW-1:0]  s_axi_awaddr,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    input  wire logic [`DPIP_DW-1:0]  s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    // axi4-lite write response
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    output logic [1:0]                s_axi_bresp,
    // axi4-lite read
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    input  wire logic [`DPIP_AW-1:0]  s_axi_araddr,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    output logic [`DPIP_DW-1:0]       s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    // sources
    input  wire logic                 can_present_pin,
    input  wire logic [`DPIP_NSRC-1:0] irq_pend,
    // results
    output dpip_pkg::dpip_levels_s    levels,
    output logic [`DPIP_NSRC-1:0]     serviceable,
    output logic                      can_present
);

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // unimplemented writes dropped
    // byte-lane merge; unimplemented bits forced to zero
    function automatic logic [15:0] dpip_merge(
        input logic [15:0]         old,
        input logic [`DPIP_DW-1:0] data,
        input logic [3:0]          strb,
        input logic [15:0]         mask
    );
        logic [15:0] be;
        be = {{8{strb[1]}}, {8{strb[0]}}};
        return ((old & ~be) | (data[15:0] & be)) & mask;
    endfunction

    // nonzero is live
    // any code other than 000 is a live level
    function automatic logic dpip_enabled(input dpip_pkg::dpip_level_t lvl);
        return lvl != `DPIP_PRIO_OFF;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // bus slave

    dpip_pkg::dpip_wr_s   wr;
    logic                 wr_fire;
    logic                 wr_ok;
    logic [`DPIP_AW-1:0]  rd_addr;
    logic                 rd_fire;
    logic [`DPIP_DW-1:0]  rd_data;
    logic                 rd_ok;

    dpip_axil_slave u_slave (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .wr            (wr),
        .wr_fire       (wr_fire),
        .wr_ok         (wr_ok),
        .rd_addr       (rd_addr),
        .rd_fire       (rd_fire),
        .rd_data       (rd_data),
        .rd_ok         (rd_ok)
    );

    ////////////////////////////////////////////////////////////////////////////
    // can strap

    logic strap_q2;
    logic strap_q3;

    dpip_sync3 u_strap_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .async_in (can_present_pin),
        .sync_q2  (strap_q2),
        .sync_q3  (strap_q3)
    );

    // absent until proven present, so can never fires early
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            can_present <= 1'b0;
        end else if (strap_q2 == strap_q3) begin
            can_present <= strap_q3;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register images

    logic [15:0] dma_ch3_priority_reg;
    logic [15:0] dma_ch4_parport_priority_reg;
    logic [15:0] can_priority_reg;

    wire wr_sel_ch3  = wr.addr == `DPIP_OFS_CH3;
    wire wr_sel_ch4  = wr.addr == `DPIP_OFS_CH4PP;
    wire wr_sel_can  = wr.addr == `DPIP_OFS_CAN;
    wire wr_sel_stat = wr.addr == `DPIP_OFS_STAT;

    assign wr_ok = wr_sel_ch3 | wr_sel_ch4 | wr_sel_can | wr_sel_stat;

    wire [15:0] ch3_next = dpip_merge(dma_ch3_priority_reg, wr.data,
                                      wr.strb, `DPIP_CH3_MASK);
    wire [15:0] ch4_next = dpip_merge(dma_ch4_parport_priority_reg, wr.data,
                                      wr.strb, `DPIP_CH4PP_MASK);
    wire [15:0] can_next = dpip_merge(can_priority_reg, wr.data,
                                      wr.strb, `DPIP_CAN_MASK);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dma_ch3_priority_reg         <= `DPIP_CH3_RST;
            dma_ch4_parport_priority_reg <= `DPIP_CH4PP_RST;
            can_priority_reg             <= `DPIP_CAN_RST;
        end else if (wr_fire) begin
            if (wr_sel_ch3) begin
                dma_ch3_priority_reg <= ch3_next;
            end
            if (wr_sel_ch4) begin
                dma_ch4_parport_priority_reg <= ch4_next;
            end
            if (wr_sel_can) begin
                can_priority_reg <= can_next;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // effective levels

    dpip_pkg::dpip_levels_s levels_next;

    assign levels_next.ch3 = dma_ch3_priority_reg[`DPIP_CH3_LSB +: `DPIP_FW];
    assign levels_next.ch4 =
        dma_ch4_parport_priority_reg[`DPIP_CH4_LSB +: `DPIP_FW];
    assign levels_next.pp  =
        dma_ch4_parport_priority_reg[`DPIP_PP_LSB +: `DPIP_FW];
    assign levels_next.can_rx = can_present ?
        can_priority_reg[`DPIP_CANRX_LSB +: `DPIP_FW] : `DPIP_PRIO_OFF;
    assign levels_next.can_evt = can_present ?
        can_priority_reg[`DPIP_CANEV_LSB +: `DPIP_FW] : `DPIP_PRIO_OFF;

    wire [`DPIP_NSRC-1:0] src_enabled = {
        dpip_enabled(levels.can_evt),
        dpip_enabled(levels.can_rx),
        dpip_enabled(levels.pp),
        dpip_enabled(levels.ch4),
        dpip_enabled(levels.ch3)
    };

    // strap gates can service
    // levels lag the strap, so a falling strap must block service by itself
    wire [`DPIP_NSRC-1:0] src_gate = {can_present, can_present, 3'h7};

    // levels lag the images by one cycle; arbiter sees a clean flop
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            levels      <= '{ch3: `DPIP_PRIO_RST, ch4: `DPIP_PRIO_RST,
                             pp: `DPIP_PRIO_RST, can_rx: `DPIP_PRIO_OFF,
                             can_evt: `DPIP_PRIO_OFF};
            serviceable <= '0;
        end else begin
            levels      <= levels_next;
            serviceable <= irq_pend & src_enabled & src_gate;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read decode

    wire rd_sel_ch3  = rd_addr == `DPIP_OFS_CH3;
    wire rd_sel_ch4  = rd_addr == `DPIP_OFS_CH4PP;
    wire rd_sel_can  = rd_addr == `DPIP_OFS_CAN;
    wire rd_sel_stat = rd_addr == `DPIP_OFS_STAT;

    wire [15:0] stat_image = {10'h000, can_present, serviceable};

    assign rd_ok = rd_sel_ch3 | rd_sel_ch4 | rd_sel_can | rd_sel_stat;

    assign rd_data = {16'h0000,
        ({16{rd_sel_ch3}}  & dma_ch3_priority_reg) |
        ({16{rd_sel_ch4}}  & dma_ch4_parport_priority_reg) |
        ({16{rd_sel_can}}  & can_priority_reg) |
        ({16{rd_sel_stat}} & stat_image)};

    ////////////////////////////////////////////////////////////////////////////
    // checks

    AST_CH3_WRITE : assert property (
        @(posedge aclk) disable iff (!aresetn)
        wr_fire && wr_sel_ch3 && wr.strb[0]
        |=> ##1 levels.ch3 == $past(wr.data[`DPIP_CH3_LSB +: `DPIP_FW], 2)
    ) else $error("ch3 level did not follow write");

    AST_CH4_WRITE : assert property (
        @(posedge aclk) disable iff (!aresetn)
        wr_fire && wr_sel_ch4 && wr.strb[1]
        |=> ##1 levels.ch4 == $past(wr.data[`DPIP_CH4_LSB +: `DPIP_FW], 2)
    ) else $error("ch4 level did not follow write");

    AST_PP_WRITE : assert property (
        @(posedge aclk) disable iff (!aresetn)
        wr_fire && wr_sel_ch4 && wr.strb[0]
        |=> ##1 levels.pp == $past(wr.data[`DPIP_PP_LSB +: `DPIP_FW], 2)
    ) else $error("port level did not follow write");

    AST_TOP_LEVEL : assert property (
        @(posedge aclk) disable iff (!aresetn)
        levels.ch4 == `DPIP_PRIO_MAX && irq_pend[1] |=> serviceable[1]
    ) else $error("level seven source not serviceable");

    AST_LOW_LEVELS : assert property (
        @(posedge aclk) disable iff (!aresetn)
        levels.pp != `DPIP_PRIO_OFF && irq_pend[2] |=> serviceable[2]
    ) else $error("enabled port source not serviceable");

    AST_DISABLED : assert property (
        @(posedge aclk) disable iff (!aresetn)
        levels.ch3 == `DPIP_PRIO_OFF |=> !serviceable[0]
    ) else $error("disabled source became serviceable");

    AST_RESET_VALUE : assert property (
        @(posedge aclk)
        !aresetn |=> dma_ch3_priority_reg == `DPIP_CH3_RST
            && dma_ch4_parport_priority_reg == `DPIP_CH4PP_RST
            && can_priority_reg == `DPIP_CAN_RST
    ) else $error("priority fields not at reset value");

    AST_RESERVED_ZERO : assert property (
        @(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000
            && (dma_ch3_priority_reg & ~`DPIP_CH3_MASK) == 16'h0000
            && (dma_ch4_parport_priority_reg & ~`DPIP_CH4PP_MASK) == 16'h0000
    ) else $error("unimplemented bits not zero");

    AST_CAN_ABSENT : assert property (
        @(posedge aclk) disable iff (!aresetn)
        !can_present |=> levels.can_rx == `DPIP_PRIO_OFF
            && levels.can_evt == `DPIP_PRIO_OFF
            && serviceable[4:3] == 2'h0
    ) else $error("can source live without can");

    COV_CH3_WRITE : cover property (
        @(posedge aclk) disable iff (!aresetn)
        wr_fire && wr_sel_ch3
    );

    COV_READ_BACK : cover property (
        @(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid && s_axi_rready && s_axi_rresp == `DPIP_RESP_OKAY
    );

    COV_DISABLED_PEND : cover property (
        @(posedge aclk) disable iff (!aresetn)
        irq_pend[0] && levels.ch3 == `DPIP_PRIO_OFF
    );

    COV_CAN_LIVE : cover property (
        @(posedge aclk) disable iff (!aresetn)
        can_present && serviceable[3]
    );

endmodule

`default_nettype wire

/* File: test/dma_pmp_irq_priority_regs_bench.sv */
/*
 * self-checking bench for the priority register block over axi4-lite.
 * assumes dpip_defines.svh on the include path and the register map it names.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dpip_defines.svh"

`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin \
    bad_count++; $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end

module dma_pmp_irq_priority_regs_bench;

    logic                      aclk;
    logic                      aresetn;
    logic                      s_axi_awvalid;
    logic                      s_axi_awready;
    logic [`DPIP_AW-1:0]       s_axi_awaddr;
    logic                      s_axi_wvalid;
    logic                      s_axi_wready;
    logic [`DPIP_DW-1:0]       s_axi_wdata;
    logic [3:0]                s_axi_wstrb;
    logic                      s_axi_bvalid;
    logic                      s_axi_bready;
    logic [1:0]                s_axi_bresp;
    logic                      s_axi_arvalid;
    logic                      s_axi_arready;
    logic [`DPIP_AW-1:0]       s_axi_araddr;
    logic                      s_axi_rvalid;
    logic                      s_axi_rready;
    logic [`DPIP_DW-1:0]       s_axi_rdata;
    logic [1:0]                s_axi_rresp;
    logic                      can_present_pin;
    logic [`DPIP_NSRC-1:0]     irq_pend;
    dpip_pkg::dpip_levels_s    levels;
    logic [`DPIP_NSRC-1:0]     serviceable;
    logic                      can_present;
    logic [1:0]                resp;
    logic [31:0]               rd;
    int                        bad_count;
    int                        checks_done;

    dpip_prio_regs u_dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .can_present_pin(can_present_pin),
        .irq_pend(irq_pend), .levels(levels), .serviceable(serviceable), .can_present(can_present)
    );

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    task automatic results();
        if (bad_count == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // one edge first, so a strobe dropped by the last call is never raised in the same step
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge aclk);
        s_axi_awvalid <= 1'b1;
        s_axi_awaddr  <= a;
        s_axi_wvalid  <= 1'b1;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= s;
        s_axi_bready  <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                resp = s_axi_bresp;
                s_axi_bready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic axi_rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr  <= a;
        s_axi_rready  <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                resp = s_axi_rresp;
                rd   = s_axi_rdata;
                s_axi_rready <= 1'b0;
                break;
            end
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5000) @(posedge aclk);
        bad_count++;
        results();
    end

    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0000_0000;
        s_axi_wstrb = 4'h0;
        can_present_pin = 1'b0;
        irq_pend = 5'h1f;
        aresetn = 1'b0;
        bad_count = 0;
        checks_done = 0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        // reset images of all three registers
        axi_rd(`DPIP_OFS_CH3);   `CHK("ch3 reset", 32'h0000_0004, rd)
        `CHK("ch3 rresp", 2'h0, resp)
        axi_rd(`DPIP_OFS_CAN);   `CHK("can reset", 32'h0000_0044, rd)
        axi_rd(`DPIP_OFS_CH4PP); `CHK("ch4pp reset", 32'h0000_0440, rd)
        `CHK("ch4 level reset", 3'h4, levels.ch4)
        // every code through the ch3 field, upper bits written as ones
        for (int c = 0; c < 8; c++) begin
            axi_wr(`DPIP_OFS_CH3, 32'hffff_fff8 | c, 4'hf);
            `CHK("ch3 bresp", 2'h0, resp)
            repeat (2) @(posedge aclk);
            `CHK("ch3 level", c[2:0], levels.ch3)
            `CHK("ch3 service", (c != 0), serviceable[0])
            axi_rd(`DPIP_OFS_CH3);
            `CHK("ch3 readback", c, rd)
        end
        // all ones in the second register, then clear only its upper byte
        axi_wr(`DPIP_OFS_CH4PP, 32'hffff_ffff, 4'hf);
        axi_rd(`DPIP_OFS_CH4PP); `CHK("ch4pp ones", 32'h0000_0770, rd)
        `CHK("ch4 level max", 3'h7, levels.ch4)
        `CHK("pp level max", 3'h7, levels.pp)
        axi_wr(`DPIP_OFS_CH4PP, 32'h0000_0000, 4'h2);
        axi_rd(`DPIP_OFS_CH4PP); `CHK("ch4 cleared", 32'h0000_0070, rd)
        repeat (2) @(posedge aclk);
        `CHK("ch4 off", 2'b10, serviceable[2:1])
        // unmapped place answers with an error and reads zero
        axi_wr(8'h10, 32'hffff_ffff, 4'hf); `CHK("unmapped bresp", 2'h3, resp)
        axi_rd(8'h10); `CHK("unmapped rresp", 2'h3, resp)
        `CHK("unmapped rdata", 32'h0000_0000, rd)
        // can sources stay off until the strap shows the module
        axi_wr(`DPIP_OFS_CAN, 32'h0000_0077, 4'hf);
        axi_rd(`DPIP_OFS_CAN); `CHK("can stored", 32'h0000_0077, rd)
        `CHK("can rx gated", 3'h0, levels.can_rx)
        `CHK("can service gated", 2'b00, serviceable[4:3])
        can_present_pin <= 1'b1;
        repeat (10) @(posedge aclk);
        `CHK("can present", 1'b1, can_present)
        `CHK("can evt level", 3'h7, levels.can_evt)
        `CHK("can service", 2'b11, serviceable[4:3])
        // status is read-only: a write answers okay and leaves it alone
        axi_wr(`DPIP_OFS_STAT, 32'h0000_0000, 4'hf); `CHK("stat bresp", 2'h0, resp)
        axi_rd(`DPIP_OFS_STAT); `CHK("stat image", 32'h0000_003d, rd)
        // nothing pending, nothing serviceable
        irq_pend <= 5'h00;
        repeat (2) @(posedge aclk);
        `CHK("no pend service", 5'h00, serviceable)
        results();
    end

endmodule

`default_nettype wire
